// file: design/pir_top.sv
// Cycle router of a PCI-to-ISA bridge: decode, ISA cycles, refresh, DMA.
// Behaviour
// - Two functions, each with own configuration space.
// - Forward target cycles; request master for DMA.
// - ISA commands, recovery, wait states, data steering.
// - Self-timed refresh drives command and row.
// - Arbiter orders refresh, DMA and PCI cycles.
// - Hold processor off during DMA cycles.
// - Reset state then active; latch strap.
// - Active state watches every transaction.
// - Claim config on IDSEL, command, AD low.
// - I/O needs enable; config always honoured.
// - Route cycles to one of five paths.
module pir_top #(
  // Identification word; the value is arbitrary.
  parameter logic [31:0] DEV_ID = 32'h5A5A0001
) (
  // Clock, reset and strap
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic           strap_mode,
  output logic                active,
  output logic                mode_latched,
  // Target requests
  input  wire logic           req_valid,
  input  pir_pkg::pir_req_t   req,
  output logic                req_ready,
  output logic                claim,
  // Responses
  output logic                rsp_valid,
  output pir_pkg::pir_rsp_t   rsp,
  input  wire logic           rsp_ready,
  // DMA and ISA master
  input  wire logic           dma_req,
  input  wire logic [31:0]    dma_addr,
  output logic                cpu_hold,
  output logic                pm_req,
  output logic [31:0]         pm_addr,
  output pir_pkg::pir_path_t  cur_path,
  // ISA bus
  output pir_pkg::pir_isa_t   isa,
  input  wire logic           isa_rdy,
  input  wire logic [15:0]    isa_rdata
);
  import pir_pkg::*;

  typedef enum logic [2:0] {
    ST_RESET, ST_IDLE, ST_ISA, ST_PUSH, ST_REC, ST_REF, ST_DMA
  } pir_state_t;

  // Reset release through two flops.
  logic rsync1_ff, rst_sync_b;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rsync1_ff  <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rsync1_ff  <= 1'b1;
      rst_sync_b <= rsync1_ff;
    end
  end

  pir_state_t  state_ff, nxt_state;
  logic [7:0]  cnt_ff, nxt_cnt;
  pir_isa_t    isa_ff, nxt_isa;
  pir_rsp_t    rsp_ff, nxt_rsp;
  pir_path_t   path_ff, nxt_path;
  logic        claim_ff, nxt_claim;
  logic        rec_ff, nxt_rec;
  logic        wr_ff, nxt_wr;
  logic        hold_ff, nxt_hold;
  logic        strap_ff, nxt_strap;
  logic [31:0] pm_addr_ff, nxt_pm_addr;
  logic [31:0] bm_reg_ff, nxt_bm_reg;
  logic [31:0] cfg_ff [NUM_FUNC][CFG_WORDS];
  logic [31:0] nxt_cfg [NUM_FUNC][CFG_WORDS];
  logic [8:0]  ref_cnt_ff, nxt_ref_cnt;
  logic [7:0]  row_ff, nxt_row;
  logic        ref_pend_ff, nxt_ref_pend;
  logic        take, cfg_we, ref_done, buf_ready;
  logic        dec_cfg, fsel;
  logic [1:0]  idx;
  pir_path_t   dec_path;

  // Address decode of the request presented this cycle.
  always_comb begin
    fsel     = req.addr[8];
    idx      = req.addr[3:2];
    dec_cfg  = is_cfg(req.cmd) && req.idsel &&
               req.addr[1:0] == CFG_TYPE0 &&
               req.addr[10:8] <= FUNC_DISK;
    dec_path = PATH_NONE;
    if (dec_cfg) begin
      dec_path = PATH_REG;
    end else if (is_io(req.cmd) && req.addr[31:16] == ZERO16) begin
      if (req.addr[15:3] == IDE_CMD_BASE) begin
        if (cfg_ff[FUNC_DISK[0]][CFG_IDX_CMD][CMD_IO_EN]) begin
          dec_path = (req.addr[2:0] == IDE_DATA_OFS && !one_byte(req.be))
                     ? PATH_PIO : PATH_CTL8;
        end
      end else if (req.addr[15:4] == BM_BASE) begin
        if (cfg_ff[FUNC_DISK[0]][CFG_IDX_CMD][CMD_IO_EN]) begin
          dec_path = PATH_REG;
        end
      end else if (cfg_ff[FUNC_BRIDGE[0]][CFG_IDX_CMD][CMD_IO_EN]) begin
        dec_path = PATH_ISA;
      end
    end else if (is_mem(req.cmd) && req.addr[31:24] == ZERO8 &&
                 cfg_ff[FUNC_BRIDGE[0]][CFG_IDX_CMD][CMD_MEM_EN]) begin
      dec_path = PATH_ISA;
    end
  end

  // Refresh is only let through from idle, ahead of DMA and PCI.
  assign req_ready = state_ff == ST_IDLE && !ref_pend_ff && !dma_req;
  assign take      = req_valid && req_ready;

  // Main sequencer.
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_isa     = isa_ff;
    nxt_rsp     = rsp_ff;
    nxt_path    = path_ff;
    nxt_claim   = 1'b0;
    nxt_rec     = rec_ff;
    nxt_wr      = wr_ff;
    nxt_strap   = strap_ff;
    nxt_pm_addr = pm_addr_ff;
    nxt_bm_reg  = bm_reg_ff;
    cfg_we      = 1'b0;
    ref_done    = 1'b0;
    case (state_ff)
      ST_RESET: begin
        nxt_strap = strap_mode;
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (ref_pend_ff) begin
          nxt_isa           = ISA_IDLE;
          nxt_isa.addr      = {ZERO16, row_ff};
          nxt_isa.refresh_b = 1'b0;
          nxt_isa.memr_b    = 1'b0;
          nxt_cnt           = CMD_CYC;
          nxt_state         = ST_REF;
        end else if (dma_req) begin
          nxt_pm_addr  = dma_addr;
          nxt_isa      = ISA_IDLE;
          nxt_isa.addr = dma_addr[23:0];
          nxt_path     = PATH_BMX;
          nxt_state    = ST_DMA;
        end else if (take && dec_path != PATH_NONE) begin
          nxt_claim = 1'b1;
          nxt_path  = dec_path;
          nxt_wr    = is_write(req.cmd);
          nxt_rsp   = '{data: 32'h00000000, path: dec_path};
          if (dec_path == PATH_REG) begin
            nxt_rec   = 1'b0;
            nxt_state = ST_PUSH;
            if (dec_cfg) begin
              cfg_we = is_write(req.cmd) && idx != CFG_IDX_ID;
              nxt_rsp.data = idx == CFG_IDX_ID ? DEV_ID : cfg_ff[fsel][idx];
            end else if (is_write(req.cmd)) begin
              nxt_bm_reg = req.wdata;
            end else begin
              nxt_rsp.data = bm_reg_ff;
            end
          end else begin
            // Latched host address and data steered onto the ISA side.
            nxt_isa         = ISA_IDLE;
            nxt_isa.addr    = req.addr[23:0];
            nxt_isa.wdata   = req.wdata[15:0];
            nxt_isa.data_oe = is_write(req.cmd);
            nxt_isa.ior_b   = req.cmd != CMD_IO_RD;
            nxt_isa.iow_b   = req.cmd != CMD_IO_WR;
            nxt_isa.memr_b  = !(is_mem(req.cmd) && !is_write(req.cmd));
            nxt_isa.memw_b  = !(is_mem(req.cmd) && is_write(req.cmd));
            nxt_cnt         = CMD_CYC;
            nxt_rec         = 1'b1;
            nxt_state       = ST_ISA;
          end
        end
      end
      ST_ISA: begin
        // A slow target stretches the command by holding ready low.
        if (cnt_ff > CNT_ONE) begin
          nxt_cnt = cnt_ff - CNT_ONE;
        end else if (isa_rdy) begin
          if (!wr_ff) begin
            nxt_rsp.data = {ZERO16, isa_rdata};
          end
          nxt_isa.ior_b   = 1'b1;
          nxt_isa.iow_b   = 1'b1;
          nxt_isa.memr_b  = 1'b1;
          nxt_isa.memw_b  = 1'b1;
          nxt_isa.data_oe = 1'b0;
          nxt_state       = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (buf_ready) begin
          nxt_cnt   = REC_CYC;
          nxt_state = rec_ff ? ST_REC : ST_IDLE;
        end
      end
      ST_REC: begin
        if (cnt_ff > CNT_ONE) begin
          nxt_cnt = cnt_ff - CNT_ONE;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_REF: begin
        if (cnt_ff > CNT_ONE) begin
          nxt_cnt = cnt_ff - CNT_ONE;
        end else begin
          nxt_isa.refresh_b = 1'b1;
          nxt_isa.memr_b    = 1'b1;
          ref_done          = 1'b1;
          nxt_cnt           = REC_CYC;
          nxt_state         = ST_REC;
        end
      end
      ST_DMA: begin
        nxt_pm_addr  = dma_addr;
        nxt_isa.addr = dma_addr[23:0];
        if (!dma_req) begin
          nxt_path  = PATH_NONE;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_hold = nxt_state == ST_DMA;
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff   <= ST_RESET;
      cnt_ff     <= 8'h00;
      isa_ff     <= ISA_IDLE;
      rsp_ff     <= '{data: 32'h00000000, path: PATH_NONE};
      path_ff    <= PATH_NONE;
      claim_ff   <= 1'b0;
      rec_ff     <= 1'b0;
      wr_ff      <= 1'b0;
      hold_ff    <= 1'b0;
      strap_ff   <= 1'b0;
      pm_addr_ff <= 32'h00000000;
      bm_reg_ff  <= 32'h00000000;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      isa_ff     <= nxt_isa;
      rsp_ff     <= nxt_rsp;
      path_ff    <= nxt_path;
      claim_ff   <= nxt_claim;
      rec_ff     <= nxt_rec;
      wr_ff      <= nxt_wr;
      hold_ff    <= nxt_hold;
      strap_ff   <= nxt_strap;
      pm_addr_ff <= nxt_pm_addr;
      bm_reg_ff  <= nxt_bm_reg;
    end
  end

  // Configuration words of both functions; word zero is read-only.
  always_comb begin
    nxt_cfg = cfg_ff;
    if (cfg_we) begin
      nxt_cfg[fsel][idx] = req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        for (int w = 0; w < CFG_WORDS; w++) begin
          cfg_ff[f][w] <= 32'h00000000;
        end
      end
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Refresh timer; a new tick wins over the clear of the pending flag.
  always_comb begin
    nxt_ref_cnt  = ref_cnt_ff == 9'h000 ? REF_CYC - REF_ONE
                                        : ref_cnt_ff - REF_ONE;
    nxt_ref_pend = (ref_cnt_ff == 9'h000) || (ref_pend_ff && !ref_done);
    nxt_row      = ref_done ? row_ff + 8'h01 : row_ff;
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ref_cnt_ff  <= 9'h000;
      ref_pend_ff <= 1'b0;
      row_ff      <= 8'h00;
    end else begin
      ref_cnt_ff  <= nxt_ref_cnt;
      ref_pend_ff <= nxt_ref_pend;
      row_ff      <= nxt_row;
    end
  end

  // A stalled reader backs the sequencer up in the push state.
  pir_buf2 u_buf (
    .mclk       (mclk),
    .rst_sync_b (rst_sync_b),
    .in_valid   (state_ff == ST_PUSH),
    .in_data    (rsp_ff),
    .in_ready   (buf_ready),
    .out_valid  (rsp_valid),
    .out_data   (rsp),
    .out_ready  (rsp_ready)
  );

  assign active       = state_ff != ST_RESET;
  assign mode_latched = strap_ff;
  assign claim        = claim_ff;
  assign cpu_hold     = hold_ff;
  assign pm_req       = state_ff == ST_DMA && dma_req;
  assign pm_addr      = pm_addr_ff;
  assign cur_path     = path_ff;
  assign isa          = isa_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  cfg_claim_a: assert property (take && dec_cfg |=> claim)
    else $error("config cycle not claimed");
  func_range_a: assert property (
    take && req.addr[10:8] > FUNC_DISK && is_cfg(req.cmd) |=> !claim)
    else $error("config claimed for a missing function");
  io_enable_a: assert property (
    take && is_io(req.cmd) && !cfg_ff[FUNC_BRIDGE[0]][CFG_IDX_CMD][CMD_IO_EN]
    && !cfg_ff[FUNC_DISK[0]][CFG_IDX_CMD][CMD_IO_EN] |=> !claim)
    else $error("I/O claimed while disabled");
  claim_path_a: assert property (claim |-> cur_path != PATH_NONE)
    else $error("claimed cycle without a path");
  cmd_width_a: assert property ($fell(isa.ior_b) |-> !isa.ior_b [*6])
    else $error("ISA read command too short");
  recovery_a: assert property (
    $rose(state_ff == ST_REC) |-> !req_ready [*8])
    else $error("request taken during recovery");
  refresh_row_a: assert property (
    $fell(isa.refresh_b) |-> isa.addr[7:0] == $past(row_ff) && !isa.memr_b)
    else $error("refresh without row address");
  ref_prio_a: assert property (ref_pend_ff |-> !req_ready)
    else $error("PCI cycle passed a pending refresh");
  dma_hold_a: assert property (
    dma_req && state_ff == ST_IDLE && !ref_pend_ff |=> cpu_hold && pm_req)
    else $error("DMA started without hold");
  dma_addr_a: assert property (
    state_ff == ST_DMA && $past(state_ff) == ST_DMA |->
    pm_addr == $past(dma_addr) && isa.addr == $past(dma_addr[23:0]))
    else $error("DMA address not sourced");
  reset_exit_a: assert property (!active && rst_sync_b |=> active)
    else $error("reset state held too long");

endmodule

// file: design/pir_pkg.sv
// Shared constants, types and decode helpers for the PCI-to-ISA cycle router.
package pir_pkg;

  // Timing, all derived from the 25 MHz clock.
  localparam int CLK_NS        = 40;
  localparam int ISA_CMD_NS    = 240;
  localparam int ISA_REC_NS    = 480;
  localparam int REF_PERIOD_NS = 15000;
  localparam logic [7:0] CMD_CYC = 8'((ISA_CMD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] REC_CYC = 8'((ISA_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] REF_CYC = 9'(REF_PERIOD_NS / CLK_NS);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [8:0] REF_ONE = 9'h001;

  // Bus commands.
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'hA;
  localparam logic [3:0] CMD_CFG_WR  = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI = 4'hF;

  // Functions and configuration layout.
  localparam int NUM_FUNC  = 2;
  localparam int CFG_WORDS = 4;
  localparam logic [2:0] FUNC_BRIDGE = 3'h0;
  localparam logic [2:0] FUNC_DISK   = 3'h1;
  localparam logic [1:0] CFG_IDX_ID  = 2'h0;
  localparam logic [1:0] CFG_IDX_CMD = 2'h1;
  localparam logic [1:0] CFG_TYPE0   = 2'h0;
  localparam int CMD_IO_EN  = 0;
  localparam int CMD_MEM_EN = 1;

  // Address decode windows.
  localparam logic [12:0] IDE_CMD_BASE = 13'h003E;
  localparam logic [11:0] BM_BASE      = 12'hCC0;
  localparam logic [2:0]  IDE_DATA_OFS = 3'h0;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  ZERO8        = 8'h00;

  typedef enum logic [2:0] {
    PATH_CTL8, PATH_PIO, PATH_REG, PATH_BMX, PATH_ISA, PATH_NONE
  } pir_path_t;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        idsel;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pir_req_t;

  typedef struct packed {
    logic [31:0] data;
    pir_path_t   path;
  } pir_rsp_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        data_oe;
    logic        ior_b;
    logic        iow_b;
    logic        memr_b;
    logic        memw_b;
    logic        refresh_b;
  } pir_isa_t;

  localparam pir_isa_t ISA_IDLE = '{addr: 24'h000000, wdata: 16'h0000,
    data_oe: 1'b0, ior_b: 1'b1, iow_b: 1'b1, memr_b: 1'b1, memw_b: 1'b1,
    refresh_b: 1'b1};

  function automatic logic is_cfg(input logic [3:0] c);
    return c == CMD_CFG_RD || c == CMD_CFG_WR;
  endfunction

  function automatic logic is_io(input logic [3:0] c);
    return c == CMD_IO_RD || c == CMD_IO_WR;
  endfunction

  function automatic logic is_mem(input logic [3:0] c);
    return c == CMD_MEM_RD || c == CMD_MEM_WR || c == CMD_MEM_RDM ||
           c == CMD_MEM_RDL || c == CMD_MEM_WRI;
  endfunction

  function automatic logic is_write(input logic [3:0] c);
    return c == CMD_IO_WR || c == CMD_MEM_WR || c == CMD_CFG_WR ||
           c == CMD_MEM_WRI;
  endfunction

  function automatic logic one_byte(input logic [3:0] be);
    return (be & (be - 4'h1)) == 4'h0;
  endfunction

endpackage

// file: design/pir_buf2.sv
// Two-entry response buffer with valid and ready on both sides.
module pir_buf2 (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_sync_b,
  // Fill side
  input  wire logic         in_valid,
  input  pir_pkg::pir_rsp_t in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output pir_pkg::pir_rsp_t out_data,
  input  wire logic         out_ready
);
  import pir_pkg::*;

  localparam int DEPTH = 2;

  pir_rsp_t   mem_ff [DEPTH];
  pir_rsp_t   nxt_mem [DEPTH];
  logic       wr_ptr_ff, nxt_wr_ptr;
  logic       rd_ptr_ff, nxt_rd_ptr;
  logic [1:0] count_ff, nxt_count;
  logic       push, pop;

  assign in_ready  = count_ff != 2'(DEPTH);
  assign out_valid = count_ff != 2'h0;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_comb begin
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    nxt_mem    = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_data;
      nxt_wr_ptr         = ~wr_ptr_ff;
    end
    if (pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '{data: 32'h00000000, path: PATH_NONE};
      end
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      mem_ff    <= nxt_mem;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

endmodule

// file: testbench/pir_isa_dev.sv
// Behavioural ISA device that answers the router's bus cycles.
module pir_isa_dev (
  // Clock
  input  wire logic         mclk,
  // Bus from the router
  input  pir_pkg::pir_isa_t isa,
  input  wire logic [3:0]   waits,
  // Answer to the router
  output logic              isa_rdy,
  output logic [15:0]       isa_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import pir_pkg::*;

  logic [3:0]  cnt_ff  = 4'h0;
  logic [15:0] last_ff = 16'hA5A5;
  logic        busy;
  logic        rd;

  assign busy = !isa.ior_b || !isa.iow_b || !isa.memr_b || !isa.memw_b;
  assign rd   = !isa.ior_b || (!isa.memr_b && isa.refresh_b);

  always_ff @(posedge mclk) begin
    cnt_ff <= busy ? ((cnt_ff == 4'hF) ? cnt_ff : cnt_ff + 4'h1) : 4'h0;
    if (rd) begin
      last_ff <= isa_rdata;
    end
  end

  // A slow device keeps ready low for its first waits cycles.
  assign isa_rdy = cnt_ff >= waits;
  // Released data lines show the inverse, so a stale sample never matches.
  assign isa_rdata = rd ? {isa.addr[7:0] ^ 8'h5A, isa.addr[15:8]} : ~last_ff;
endmodule

// file: testbench/pir_top_tb_top.sv
// Self-checking testbench of the PCI-to-ISA cycle router.
module pir_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pir_pkg::*;

  // Identification word; the value is arbitrary.
  localparam logic [31:0] ID_WORD = 32'h1234_8765;
  localparam logic [3:0] CMDS [7] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD,
    CMD_MEM_WR, CMD_MEM_RDM, CMD_MEM_RDL, CMD_MEM_WRI};

  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        strap_mode = 1'b1;
  logic        active, mode_latched, req_ready, claim, rsp_valid;
  logic        req_valid = 1'b0;
  pir_req_t    req = '0;
  pir_rsp_t    rsp;
  logic        rsp_ready = 1'b1;
  logic        dma_req = 1'b0;
  logic [31:0] dma_addr = 32'h0;
  logic        cpu_hold, pm_req, isa_rdy;
  logic [31:0] pm_addr;
  pir_path_t   cur_path;
  pir_isa_t    isa;
  logic [15:0] isa_rdata;
  logic [3:0]  waits = 4'h0;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  pir_rsp_t    rq [$];

  pir_top #(.DEV_ID(ID_WORD)) pir_top_i (.mclk(mclk), .rst_b(rst_b),
    .strap_mode(strap_mode), .active(active), .mode_latched(mode_latched),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .claim(claim),
    .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready),
    .dma_req(dma_req), .dma_addr(dma_addr), .cpu_hold(cpu_hold),
    .pm_req(pm_req), .pm_addr(pm_addr), .cur_path(cur_path), .isa(isa),
    .isa_rdy(isa_rdy), .isa_rdata(isa_rdata));
  pir_isa_dev pir_isa_dev_i (.mclk(mclk), .isa(isa), .waits(waits),
    .isa_rdy(isa_rdy), .isa_rdata(isa_rdata));

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      rq.push_back(rsp);
    end
  end

  // The ceiling leaves ample room over the fewer than one thousand cycles needed.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic strb(input logic [3:0] c);
    if (c == CMD_IO_RD) return isa.ior_b;
    if (c == CMD_IO_WR) return isa.iow_b;
    if (c == CMD_MEM_WR || c == CMD_MEM_WRI) return isa.memw_b;
    return isa.memr_b;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic issue(input pir_req_t r, output logic cl);
    int n;
    @(posedge mclk);
    #1;
    req = r;
    req_valid = 1'b1;
    n = 0;
    // Ready is judged between edges; the claim pulse lasts one cycle only.
    while (req_ready !== 1'b1 && n < 100) begin
      cycles(1);
      n++;
    end
    cycles(1);
    req_valid = 1'b0;
    cl = claim;
  endtask

  task automatic cfg(input logic wr, input logic [2:0] f, input logic [1:0] w,
                     input logic [31:0] d, input logic sel,
                     input logic [1:0] lo, output logic cl);
    issue('{cmd: wr ? CMD_CFG_WR : CMD_CFG_RD, addr: {21'h0, f, 4'h0, w, lo},
            idsel: sel, be: 4'hF, wdata: d}, cl);
  endtask

  task automatic pop(input logic [31:0] d, input pir_path_t p, input logic dk);
    pir_rsp_t r;
    int n;
    n = 0;
    while (rq.size() == 0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (rq.size() == 0) begin
      chk_bit("response present", 1'b1, 1'b0);
    end else begin
      r = rq.pop_front();
      if (dk) chk_word("rsp data", d, r.data);
      chk_word("rsp path", {29'h0, p}, {29'h0, r.path});
    end
  endtask

  task automatic t_reset(input logic s);
    int n;
    @(posedge mclk);
    #1;
    rst_b = 1'b0;
    strap_mode = s;
    cycles(2);
    chk_bit("active in reset", 1'b0, active);
    chk_bit("ior idle", 1'b1, isa.ior_b);
    chk_bit("refresh idle", 1'b1, isa.refresh_b);
    rst_b = 1'b1;
    n = 0;
    while (active !== 1'b1 && n < 10) begin
      cycles(1);
      n++;
    end
    chk_bit("active", 1'b1, active);
    chk_bit("strap", s, mode_latched);
    $display("reset test done");
  endtask

  task automatic t_refresh();
    logic [7:0] row;
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (isa.refresh_b !== 1'b0 && n < 800) begin
        cycles(1);
        n++;
      end
      chk_bit("refresh memr", 1'b0, isa.memr_b);
      chk_word("refresh upper", 32'h0, {16'h0, isa.addr[23:8]});
      chk_bit("refresh blocks pci", 1'b0, req_ready);
      if (k == 1) chk_word("row step", {24'h0, row + 8'h01},
                           {24'h0, isa.addr[7:0]});
      row = isa.addr[7:0];
      n = 0;
      while (isa.refresh_b === 1'b0 && n < 40) begin
        cycles(1);
        n++;
      end
      chk_word("refresh length", 32'(CMD_CYC), n);
    end
    $display("refresh test done");
  endtask

  task automatic t_config();
    logic cl;
    cfg(1'b0, FUNC_BRIDGE, CFG_IDX_ID, 32'h0, 1'b1, 2'h0, cl);
    chk_bit("cfg claim f0", 1'b1, cl);
    pop(ID_WORD, PATH_REG, 1'b1);
    cfg(1'b0, FUNC_DISK, CFG_IDX_ID, 32'h0, 1'b1, 2'h0, cl);
    chk_bit("cfg claim f1", 1'b1, cl);
    pop(ID_WORD, PATH_REG, 1'b1);
    cfg(1'b0, FUNC_BRIDGE, CFG_IDX_ID, 32'h0, 1'b0, 2'h0, cl);
    chk_bit("cfg no idsel", 1'b0, cl);
    cfg(1'b0, FUNC_BRIDGE, CFG_IDX_ID, 32'h0, 1'b1, 2'h1, cl);
    chk_bit("cfg low bits", 1'b0, cl);
    cfg(1'b0, 3'h2, CFG_IDX_ID, 32'h0, 1'b1, 2'h0, cl);
    chk_bit("cfg no func2", 1'b0, cl);
    cfg(1'b1, FUNC_BRIDGE, 2'h2, 32'h1111_2222, 1'b1, 2'h0, cl);
    pop(32'h0, PATH_REG, 1'b1);
    cfg(1'b1, FUNC_DISK, 2'h2, 32'h3333_4444, 1'b1, 2'h0, cl);
    pop(32'h0, PATH_REG, 1'b1);
    chk_word("unclaimed silent", 32'h0, rq.size());
    $display("config test done");
  endtask

  task automatic t_enable();
    logic cl;
    issue('{cmd: CMD_IO_RD, addr: 32'h1F0, idsel: 1'b0, be: 4'h1,
            wdata: 32'h0}, cl);
    chk_bit("io disabled", 1'b0, cl);
    cfg(1'b1, FUNC_DISK, CFG_IDX_CMD, 32'h1, 1'b1, 2'h0, cl);
    pop(32'h0, PATH_REG, 1'b1);
    cfg(1'b1, FUNC_BRIDGE, CFG_IDX_CMD, 32'h3, 1'b1, 2'h0, cl);
    pop(32'h0, PATH_REG, 1'b1);
    cfg(1'b0, FUNC_DISK, CFG_IDX_CMD, 32'h0, 1'b1, 2'h0, cl);
    pop(32'h1, PATH_REG, 1'b1);
    issue('{cmd: CMD_IO_RD, addr: 32'h1F0, idsel: 1'b0, be: 4'h1,
            wdata: 32'h0}, cl);
    chk_bit("io ctl8 claim", 1'b1, cl);
    pop(32'h0, PATH_CTL8, 1'b0);
    issue('{cmd: CMD_IO_RD, addr: 32'h1F0, idsel: 1'b0, be: 4'hF,
            wdata: 32'h0}, cl);
    pop(32'h0, PATH_PIO, 1'b0);
    issue('{cmd: CMD_IO_RD, addr: 32'hCC04, idsel: 1'b0, be: 4'hF,
            wdata: 32'h0}, cl);
    pop(32'h0, PATH_REG, 1'b0);
    $display("enable test done");
  endtask

  task automatic isa_cyc(input logic [3:0] c, input logic [31:0] a,
                         input logic [3:0] w);
    logic cl;
    logic wr;
    int n;
    wr = c == CMD_IO_WR || c == CMD_MEM_WR || c == CMD_MEM_WRI;
    waits = w;
    issue('{cmd: c, addr: a, idsel: 1'b0, be: 4'h3,
            wdata: {16'h0, a[15:0] ^ 16'h1234}}, cl);
    chk_bit("isa claim", 1'b1, cl);
    chk_bit("isa strobe", 1'b0, strb(c));
    chk_word("isa addr", a & 32'h00FF_FFFF, {8'h0, isa.addr});
    if (wr) begin
      chk_bit("isa drive", 1'b1, isa.data_oe);
      chk_word("isa wdata", {16'h0, a[15:0] ^ 16'h1234},
               {16'h0, isa.wdata});
    end
    n = 0;
    while (strb(c) === 1'b0 && n < 40) begin
      n++;
      cycles(1);
    end
    chk_bit("isa length", 1'b1, (w == 4'h0) ? n == CMD_CYC :
            (n > CMD_CYC && n <= w + 3));
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      n++;
      cycles(1);
    end
    chk_bit("recovery", 1'b1, n >= REC_CYC);
    pop(wr ? 32'h0 : {16'h0, a[7:0] ^ 8'h5A, a[15:8]}, PATH_ISA, 1'b1);
    waits = 4'h0;
  endtask

  task automatic t_isa();
    foreach (CMDS[i]) begin
      isa_cyc(CMDS[i], is_io(CMDS[i]) ? 32'h0300 : 32'h000A_1230, 4'h0);
    end
    isa_cyc(CMD_IO_RD, 32'h0378, 4'h9);
    $display("isa test done");
  endtask

  task automatic t_dma();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      cycles(1);
      n++;
    end
    dma_addr = 32'h0012_3450;
    dma_req = 1'b1;
    n = 0;
    while (cpu_hold !== 1'b1 && n < 40) begin
      cycles(1);
      n++;
    end
    cycles(1);
    chk_bit("cpu hold", 1'b1, cpu_hold);
    chk_bit("master request", 1'b1, pm_req);
    chk_word("dma path", {29'h0, PATH_BMX}, {29'h0, cur_path});
    chk_word("dma address", dma_addr, pm_addr);
    chk_bit("pci held off", 1'b0, req_ready);
    dma_req = 1'b0;
    cycles(2);
    chk_bit("hold released", 1'b0, cpu_hold);
    chk_bit("request released", 1'b0, pm_req);
    $display("dma test done");
  endtask

  task automatic t_buffer();
    logic cl;
    rsp_ready = 1'b0;
    cfg(1'b0, FUNC_BRIDGE, 2'h2, 32'h0, 1'b1, 2'h0, cl);
    cfg(1'b0, FUNC_DISK, 2'h2, 32'h0, 1'b1, 2'h0, cl);
    cfg(1'b0, FUNC_BRIDGE, CFG_IDX_ID, 32'h0, 1'b1, 2'h0, cl);
    cycles(5);
    chk_bit("buffer holds", 1'b1, rsp_valid);
    chk_bit("stalled router", 1'b0, req_ready);
    rsp_ready = 1'b1;
    pop(32'h1111_2222, PATH_REG, 1'b1);
    pop(32'h3333_4444, PATH_REG, 1'b1);
    pop(ID_WORD, PATH_REG, 1'b1);
    $display("buffer test done");
  endtask

  initial begin
    t_reset(1'b1);
    t_refresh();
    t_config();
    t_enable();
    t_isa();
    t_dma();
    t_buffer();
    t_reset(1'b0);
    close_out();
  end
endmodule
